// ### design/ifms_top.sv
// interrupt flags, masks, group summary and host dma pipeline tracking
// assumes masks and clear strobes come from processor register writes
//
// Contract
// [R1] two separate interrupt output pins for single or dual pin use
// [R2] sources gather into host buffer, disk buffer, sequencer, error groups
// [R3] changing any mask bit never clears a pending flag
// [R4] a flag clears only when a one is written to its status bit
// [R5] flags and summary bits set whatever the mask bits hold
// [R6] a pin needs both the individual and the group mask bit
// [R7] each individual mask bit pairs with the flag at its position
// [R8] per pin, summary masks choose which groups may drive it
// [R9] single pin use: software enables every group on the first pin
// [R10] dual pin use: software steers each group to one pin
// [R11] every status bit is readable at any time, masked or not
// [R12] host pipeline has exactly idle, busy and very busy states
// [R13] each state change raises busy or very busy unless parity pending; an abort to idle raises neither
// [R14] pipeline transitions depend on direction; high writes the buffer
// [R15] busy and very busy are separate host status bits
// [R16] host error raised on host or buffer parity, or very very busy
// [R17] parity error flags at once, without any state change
// [R18] parity error pauses the pipeline and suppresses busy interrupts
// [R19] a write to the dma control register makes a one-cycle start
// [R20] a write to the stop bit aborts the pipeline
// [R21] start while very busy sets the very very busy flag
// [R22] pin high while an allowed group holds an unmasked pending flag
// [R23] start steps up, count expiry steps down, abort returns idle
`timescale 1ns/1ps
`include "ifms_defines.svh"
module ifms_top #(
    parameter int FLAG_W = `IFMS_FLAG_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // host pipeline controls
    input  wire logic              dma_ctl_wr,
    input  wire logic              stop_wr,
    input  wire logic              xfer_cnt_expired,
    input  wire logic              dir,
    input  wire logic              fifo_empty_flag,
    input  wire logic              host_bus_parity_err,
    input  wire logic              buffer_bus_parity_err,
    // disk side events, one-cycle pulses
    input  wire logic [FLAG_W-1:0] disk_buf_evt,
    input  wire logic [FLAG_W-1:0] disk_seq_evt,
    input  wire logic [FLAG_W-1:0] disk_err_evt,
    // write-one-to-clear, one strobe per group
    input  wire logic [3:0]        clr_we,
    input  wire logic [FLAG_W-1:0] clr_data,
    // individual masks
    input  wire logic [FLAG_W-1:0] mask_host,
    input  wire logic [FLAG_W-1:0] mask_dbuf,
    input  wire logic [FLAG_W-1:0] mask_dseq,
    input  wire logic [FLAG_W-1:0] mask_derr,
    // summary masks, one per pin
    input  wire logic [3:0]        sum_mask_a,
    input  wire logic [3:0]        sum_mask_b,
    // status
    output logic [FLAG_W-1:0]      host_buffer_irq_status,
    output logic [FLAG_W-1:0]      disk_buffer_irq_status,
    output logic [FLAG_W-1:0]      disk_seq_irq_status,
    output logic [FLAG_W-1:0]      disk_err_irq_status,
    output logic [3:0]             group_summary_first,
    output logic [2:0]             pipe_state,
    // interrupt pins
    output logic                   irq_out_a,
    output logic                   irq_out_b
);

    ////////////////////////////////////////////////////////////////////
    // state and internal signals
    ifms_pkg::ifms_top_s s;
    ifms_pkg::ifms_top_s next_s;

    logic [FLAG_W-1:0] host_set;
    logic [FLAG_W-1:0] set_v   [4];
    logic [FLAG_W-1:0] mask_v  [4];
    logic [FLAG_W-1:0] flags_v [4];
    logic [3:0]        grp_pend;
    logic [3:0]        grp_any;
    logic              parity_now;
    logic              parity_out;
    logic              hold;
    logic              done;

    ////////////////////////////////////////////////////////////////////
    // group wiring: host buffer, disk buffer, sequencer, disk error
    assign set_v[`IFMS_GRP_HOST]  = host_set; // R2
    assign set_v[`IFMS_GRP_DBUF]  = disk_buf_evt;
    assign set_v[`IFMS_GRP_DSEQ]  = disk_seq_evt;
    assign set_v[`IFMS_GRP_DERR]  = disk_err_evt;
    assign mask_v[`IFMS_GRP_HOST] = mask_host;
    assign mask_v[`IFMS_GRP_DBUF] = mask_dbuf;
    assign mask_v[`IFMS_GRP_DSEQ] = mask_dseq;
    assign mask_v[`IFMS_GRP_DERR] = mask_derr;

    // one sticky flag bank per group, mask bit n gates flag bit n
    for (genvar g = 0; g < `IFMS_GRP_N; g++) begin : g_bank
        ifms_flag_bank #(
            .W        (FLAG_W)
        ) u_bank (
            .clk      (clk),
            .rst      (rst),
            .set      (set_v[g]),
            .clr_we   (clr_we[g]),
            .clr_data (clr_data),
            .mask     (mask_v[g]),
            .flags    (flags_v[g]),
            .pend     (grp_pend[g]),
            .any      (grp_any[g])
        ); // R3 R4 R7
    end

    ////////////////////////////////////////////////////////////////////
    // two output pins, each with its own group steering
    ifms_pin_route #(
        .G          (4)
    ) u_pin_a (
        .clk        (clk),
        .rst        (rst),
        .group_pend (grp_pend),
        .sum_mask   (sum_mask_a),
        .pin        (irq_out_a)
    ); // R1 R6 R8 R22

    ifms_pin_route #(
        .G          (4)
    ) u_pin_b (
        .clk        (clk),
        .rst        (rst),
        .group_pend (grp_pend),
        .sum_mask   (sum_mask_b),
        .pin        (irq_out_b)
    ); // R1 R8 R22

    ////////////////////////////////////////////////////////////////////
    // pause conditions and completion of the active transfer
    assign parity_now = host_bus_parity_err | buffer_bus_parity_err;
    assign parity_out = flags_v[`IFMS_GRP_HOST][`IFMS_HB_HPE]
                      | flags_v[`IFMS_GRP_HOST][`IFMS_HB_BPE];
    assign hold       = parity_now | parity_out; // R18
    // writes to the buffer finish only once the fifo has drained
    assign done = (s.cnt_exp | xfer_cnt_expired)
                & (~dir | fifo_empty_flag); // R14

    // next state: start pulse, pipeline moves and host events
    always_comb begin
        next_s                      = s;
        host_set                    = '0;
        next_s.wr_seen              = dma_ctl_wr;
        next_s.start                = dma_ctl_wr & ~s.wr_seen; // R19
        next_s.summary              = grp_any; // R5
        if (xfer_cnt_expired) begin
            next_s.cnt_exp = 1'b1;
        end
        host_set[`IFMS_HB_HPE]      = host_bus_parity_err; // R17
        host_set[`IFMS_HB_BPE]      = buffer_bus_parity_err; // R17
        if (s.start && s.pipe == ifms_pkg::IFMS_VBUSY) begin
            host_set[`IFMS_HB_VVBUSY] = 1'b1; // R21
        end
        if (stop_wr) begin
            next_s.pipe    = ifms_pkg::IFMS_IDLE; // R20
            next_s.cnt_exp = 1'b0;
        end else if (!hold) begin
            case (s.pipe)
                ifms_pkg::IFMS_IDLE: begin
                    next_s.cnt_exp = 1'b0;
                    if (s.start) begin
                        next_s.pipe              = ifms_pkg::IFMS_BUSY;
                        host_set[`IFMS_HB_BUSY]  = 1'b1; // R13
                    end
                end
                ifms_pkg::IFMS_BUSY: begin
                    if (s.start && done) begin
                        next_s.cnt_exp           = 1'b0;
                        host_set[`IFMS_HB_BUSY]  = 1'b1;
                    end else if (s.start) begin
                        next_s.pipe              = ifms_pkg::IFMS_VBUSY;
                        host_set[`IFMS_HB_VBUSY] = 1'b1; // R13 R15
                    end else if (done) begin
                        next_s.pipe              = ifms_pkg::IFMS_IDLE;
                        next_s.cnt_exp           = 1'b0;
                        host_set[`IFMS_HB_BUSY]  = 1'b1; // R23
                    end
                end
                ifms_pkg::IFMS_VBUSY: begin
                    if (done && !s.start) begin
                        next_s.pipe              = ifms_pkg::IFMS_BUSY;
                        next_s.cnt_exp           = 1'b0;
                        host_set[`IFMS_HB_BUSY]  = 1'b1; // R23
                    end else if (done) begin
                        next_s.cnt_exp           = 1'b0;
                        host_set[`IFMS_HB_VBUSY] = 1'b1;
                    end
                end
                default: begin
                    next_s.pipe = ifms_pkg::IFMS_IDLE; // R12
                end
            endcase
        end
        host_set[`IFMS_HB_ERR] = host_set[`IFMS_HB_HPE]
                               | host_set[`IFMS_HB_BPE]
                               | host_set[`IFMS_HB_VVBUSY]; // R16
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s.pipe    <= ifms_pkg::IFMS_IDLE;
            s.wr_seen <= 1'b0;
            s.start   <= 1'b0;
            s.cnt_exp <= 1'b0;
            s.summary <= `IFMS_SUM_RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign host_buffer_irq_status = flags_v[`IFMS_GRP_HOST]; // R11
    assign disk_buffer_irq_status = flags_v[`IFMS_GRP_DBUF];
    assign disk_seq_irq_status    = flags_v[`IFMS_GRP_DSEQ];
    assign disk_err_irq_status    = flags_v[`IFMS_GRP_DERR];
    assign group_summary_first    = s.summary;
    assign pipe_state             = s.pipe;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_start_idle;
        s.pipe == ifms_pkg::IFMS_IDLE && s.start && !stop_wr && !hold;
    endsequence

    sequence s_busy_flagged;
        s.pipe == ifms_pkg::IFMS_BUSY
            && host_buffer_irq_status[`IFMS_HB_BUSY];
    endsequence

    sequence s_write_edge;
        dma_ctl_wr && !s.wr_seen;
    endsequence

    // parity flags appear on the next edge
    property p_hpe_now;
        host_bus_parity_err |=> host_buffer_irq_status[`IFMS_HB_HPE]
            && host_buffer_irq_status[`IFMS_HB_ERR];
    endproperty
    a_hpe_now: assert property (p_hpe_now) // R17
        else $error("host parity flag not set");

    property p_bpe_now;
        buffer_bus_parity_err |=> host_buffer_irq_status[`IFMS_HB_BPE]
            && host_buffer_irq_status[`IFMS_HB_ERR];
    endproperty
    a_bpe_now: assert property (p_bpe_now) // R16
        else $error("buffer parity flag not set");

    // start from idle reaches busy with its flag
    property p_idle_start;
        s_start_idle |=> s_busy_flagged;
    endproperty
    a_idle_start: assert property (p_idle_start) // R23
        else $error("start from idle did not flag busy");

    // start pulse is one cycle after a write edge
    property p_start_pulse;
        s_write_edge |=> s.start ##1 !s.start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) // R19
        else $error("start pulse wrong");

    property p_vvbusy;
        s.pipe == ifms_pkg::IFMS_VBUSY && s.start
            |=> host_buffer_irq_status[`IFMS_HB_VVBUSY];
    endproperty
    a_vvbusy: assert property (p_vvbusy) // R21
        else $error("very very busy not flagged");

    property p_abort;
        stop_wr |=> s.pipe == ifms_pkg::IFMS_IDLE;
    endproperty
    a_abort: assert property (p_abort) // R20
        else $error("abort did not return idle");

    // pipeline frozen and no busy flag raised under parity
    property p_pause;
        hold && !stop_wr |=> $stable(s.pipe);
    endproperty
    a_pause: assert property (p_pause) // R18
        else $error("pipeline moved under parity error");

    property p_no_busy_irq;
        hold && !host_buffer_irq_status[`IFMS_HB_BUSY]
            |=> !host_buffer_irq_status[`IFMS_HB_BUSY];
    endproperty
    a_no_busy_irq: assert property (p_no_busy_irq) // R13
        else $error("busy flagged under parity error");

    // flag stays until a one is written to it
    property p_sticky;
        host_buffer_irq_status[`IFMS_HB_BUSY]
            && !(clr_we[`IFMS_GRP_HOST] && clr_data[`IFMS_HB_BUSY])
            |=> host_buffer_irq_status[`IFMS_HB_BUSY];
    endproperty
    a_sticky: assert property (p_sticky) // R3
        else $error("flag lost without clear");

    property p_clear;
        clr_we[`IFMS_GRP_HOST] && clr_data[`IFMS_HB_VBUSY]
            && !host_set[`IFMS_HB_VBUSY]
            |=> !host_buffer_irq_status[`IFMS_HB_VBUSY];
    endproperty
    a_clear: assert property (p_clear) // R4
        else $error("flag not cleared by write of one");

    // pins follow allowed, unmasked groups one cycle later
    property p_pin_a;
        |(grp_pend & sum_mask_a) |=> irq_out_a;
    endproperty
    a_pin_a: assert property (p_pin_a) // R22
        else $error("pin a not raised");

    property p_pin_b_low;
        !(|(grp_pend & sum_mask_b)) |=> !irq_out_b;
    endproperty
    a_pin_b_low: assert property (p_pin_b_low) // R6
        else $error("pin b raised without allowed pending");

    property p_summary;
        |disk_err_irq_status |=> group_summary_first[`IFMS_GRP_DERR];
    endproperty
    a_summary: assert property (p_summary) // R5
        else $error("summary bit missing");

    // writes to buffer wait for an empty fifo
    property p_dir_wait;
        s.pipe == ifms_pkg::IFMS_BUSY && s.cnt_exp && dir
            && !fifo_empty_flag && !s.start && !stop_wr
            |=> s.pipe == ifms_pkg::IFMS_BUSY;
    endproperty
    a_dir_wait: assert property (p_dir_wait) // R14
        else $error("busy ended before fifo drained");

    property p_onehot;
        $onehot(s.pipe);
    endproperty
    a_onehot: assert property (p_onehot) // R12
        else $error("pipeline state not one-hot");

endmodule

// ### inc/ifms_defines.svh
// constants of the interrupt flag, mask and summary block
// assumes one clock domain and a synchronous active-high reset
`ifndef IFMS_DEFINES_SVH
`define IFMS_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// group indices in the summary and group mask vectors
`define IFMS_GRP_N       4
`define IFMS_GRP_HOST    0
`define IFMS_GRP_DBUF    1
`define IFMS_GRP_DSEQ    2
`define IFMS_GRP_DERR    3

////////////////////////////////////////////////////////////////////////
// host buffer status bit positions
`define IFMS_HB_BUSY     0
`define IFMS_HB_VBUSY    1
`define IFMS_HB_ERR      2
`define IFMS_HB_HPE      3
`define IFMS_HB_BPE      4
`define IFMS_HB_VVBUSY   5

////////////////////////////////////////////////////////////////////////
// widths and reset values
`define IFMS_FLAG_W      8
`define IFMS_FLAG_RST    8'h00
`define IFMS_SUM_RST     4'h0

`endif

// ### inc/ifms_pkg.sv
// types of the interrupt flag, mask and summary block
// assumes the constants header is compiled alongside
package ifms_pkg;

    // host dma pipeline states, one-hot
    typedef enum logic [2:0] {
        IFMS_IDLE  = 3'b001,
        IFMS_BUSY  = 3'b010,
        IFMS_VBUSY = 3'b100
    } ifms_pipe_e;

    // state of the top module
    typedef struct packed {
        ifms_pipe_e pipe;
        logic       wr_seen;
        logic       start;
        logic       cnt_exp;
        logic [3:0] summary;
    } ifms_top_s;

endpackage

// ### design/ifms_flag_bank.sv
// one group of sticky interrupt flags with write-one-to-clear
// assumes set and clear strobes are synchronous to clk
`timescale 1ns/1ps
module ifms_flag_bank #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // events and processor clear
    input  wire logic [W-1:0] set,
    input  wire logic         clr_we,
    input  wire logic [W-1:0] clr_data,
    // individual mask
    input  wire logic [W-1:0] mask,
    // status
    output logic      [W-1:0] flags,
    output logic              pend,
    output logic              any
);

    typedef struct packed {
        logic [W-1:0] flags;
    } ifms_bank_s;

    ifms_bank_s s;
    ifms_bank_s next_s;

    // set wins over a clear in the same cycle; masks never clear
    always_comb begin
        next_s = s;
        if (clr_we) begin
            next_s.flags = s.flags & ~clr_data;
        end
        next_s.flags = next_s.flags | set;
    end

    // flag register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // status and unmasked pending
    assign flags = s.flags;
    assign pend  = |(s.flags & mask);
    assign any   = |s.flags;

endmodule

// ### design/ifms_pin_route.sv
// steers pending groups through a summary mask onto one output pin
// assumes group pending terms are already individually masked
`timescale 1ns/1ps
module ifms_pin_route #(
    parameter int G = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // groups and summary mask
    input  wire logic [G-1:0] group_pend,
    input  wire logic [G-1:0] sum_mask,
    // pin
    output logic              pin
);

    typedef struct packed {
        logic pin;
    } ifms_pin_s;

    ifms_pin_s s;
    ifms_pin_s next_s;

    // pin follows any allowed, unmasked pending group
    always_comb begin
        next_s     = s;
        next_s.pin = |(group_pend & sum_mask);
    end

    // pin register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pin = s.pin;

endmodule

// ### testbench/ifms_cpu_model.sv
// processor side model: dma control writes, stop, clears, group masks
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/1ps
module ifms_cpu_model (
    // clock
    input  wire logic       clk,
    // pipeline control writes
    output logic            dma_ctl_wr,
    output logic            stop_wr,
    // write-one-to-clear
    output logic [3:0]      clr_we,
    output logic [7:0]      clr_data,
    // summary masks
    output logic [3:0]      sum_mask_a,
    output logic [3:0]      sum_mask_b
);
    ////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        dma_ctl_wr = 1'b0;
        stop_wr    = 1'b0;
        clr_we     = 4'h0;
        clr_data   = 8'h00;
        sum_mask_a = 4'h0;
        sum_mask_b = 4'h0;
    end

    // clear by writing ones to the source status byte
    task automatic wr_clear(input int g, input logic [7:0] d);
        clr_we[g] = 1'b1;
        clr_data  = d;
        @(negedge clk);
        clr_we   = 4'h0;
        clr_data = ~d; // released data no longer holds the value
    endtask

    // dma control write, low again before the next one
    task automatic start();
        dma_ctl_wr = 1'b1;
        @(negedge clk);
        dma_ctl_wr = 1'b0;
        @(negedge clk);
    endtask

    // write to the pipeline stop bit
    task automatic abort();
        stop_wr = 1'b1;
        @(negedge clk);
        stop_wr = 1'b0;
    endtask

    // group steering for single or dual pin use
    task automatic set_sum(input logic [3:0] a, input logic [3:0] b);
        sum_mask_a = a;
        sum_mask_b = b;
    endtask
endmodule

// ### testbench/test_interrupt_flag_mask_summary.sv
// self-checking bench for the interrupt flag, mask and summary block
// assumes the processor model file is compiled before this one
`timescale 1ns/1ps
module test_interrupt_flag_mask_summary;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       xfer_cnt_expired = 1'b0;
    logic       dir = 1'b0;
    logic       fifo_empty_flag = 1'b0;
    logic       host_bus_parity_err = 1'b0;
    logic       buffer_bus_parity_err = 1'b0;
    logic [7:0] evt [4] = '{default: 8'h00};
    logic [7:0] msk [4] = '{default: 8'h00};
    logic [7:0] st [4];
    logic       dma_ctl_wr, stop_wr;
    logic [3:0] clr_we, sum_mask_a, sum_mask_b, summ;
    logic [7:0] clr_data;
    logic [2:0] pipe_state;
    logic       irq_out_a, irq_out_b;
    int         error_cnt = 0;
    int         num_checks = 0;

    ////////////////////////////////////////////////////////////////////
    // 50 ns clock
    always #25 clk = ~clk;

    ifms_cpu_model i_cpu (
        .clk        (clk),
        .dma_ctl_wr (dma_ctl_wr),
        .stop_wr    (stop_wr),
        .clr_we     (clr_we),
        .clr_data   (clr_data),
        .sum_mask_a (sum_mask_a),
        .sum_mask_b (sum_mask_b)
    );

    ifms_top i_dut (
        .clk                    (clk),
        .rst                    (rst),
        .dma_ctl_wr             (dma_ctl_wr),
        .stop_wr                (stop_wr),
        .xfer_cnt_expired       (xfer_cnt_expired),
        .dir                    (dir),
        .fifo_empty_flag        (fifo_empty_flag),
        .host_bus_parity_err    (host_bus_parity_err),
        .buffer_bus_parity_err  (buffer_bus_parity_err),
        .disk_buf_evt           (evt[1]),
        .disk_seq_evt           (evt[2]),
        .disk_err_evt           (evt[3]),
        .clr_we                 (clr_we),
        .clr_data               (clr_data),
        .mask_host              (msk[0]),
        .mask_dbuf              (msk[1]),
        .mask_dseq              (msk[2]),
        .mask_derr              (msk[3]),
        .sum_mask_a             (sum_mask_a),
        .sum_mask_b             (sum_mask_b),
        .host_buffer_irq_status (st[0]),
        .disk_buffer_irq_status (st[1]),
        .disk_seq_irq_status    (st[2]),
        .disk_err_irq_status    (st[3]),
        .group_summary_first    (summ),
        .pipe_state             (pipe_state),
        .irq_out_a              (irq_out_a),
        .irq_out_b              (irq_out_b)
    );

    ////////////////////////////////////////////////////////////////////
    // comparison, stepping and verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one-cycle transfer count expiry pulse
    task automatic expire();
        xfer_cnt_expired = 1'b1;
        step(1);
        xfer_cnt_expired = 1'b0;
        step(2);
    endtask

    ////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] b;
        step(6);
        rst = 1'b0;
        chk(st[0], 8'h00);
        chk({4'h0, summ}, 8'h00);
        chk({5'h00, pipe_state}, 8'h01);
        chk({6'h00, irq_out_a, irq_out_b}, 8'h00);
        // disk groups: set while masked, both mask levels, steering, clear
        for (int g = 1; g < 4; g++) begin
            b = 8'h01 << (g + 2);
            evt[g] = b;
            step(1);
            evt[g] = 8'h00;
            chk(st[g], b);
            step(1);
            chk({4'h0, summ}, 8'h01 << g);
            chk({7'h00, irq_out_a}, 8'h00);
            msk[g] = b;
            step(2);
            chk({7'h00, irq_out_a}, 8'h00);
            i_cpu.set_sum(4'h1 << g, 4'h0);
            step(2);
            chk({6'h00, irq_out_a, irq_out_b}, 8'h02);
            i_cpu.set_sum(4'h0, 4'h1 << g);
            step(2);
            chk({6'h00, irq_out_a, irq_out_b}, 8'h01);
            msk[g] = ~b;
            step(2);
            chk({7'h00, irq_out_b}, 8'h00);
            chk(st[g], b);
            msk[g] = b;
            i_cpu.wr_clear(g, ~b);
            step(1);
            chk(st[g], b);
            i_cpu.wr_clear(g, b);
            step(1);
            chk(st[g], 8'h00);
            chk({6'h00, irq_out_a, irq_out_b}, 8'h00);
            msk[g] = 8'h00;
        end
        // pipeline up through very busy and very very busy
        i_cpu.start();
        step(1);
        chk({5'h00, pipe_state}, 8'h02);
        chk(st[0], 8'h01);
        i_cpu.wr_clear(0, 8'hff);
        i_cpu.start();
        step(1);
        chk({5'h00, pipe_state}, 8'h04);
        chk(st[0], 8'h02);
        i_cpu.wr_clear(0, 8'hff);
        i_cpu.start();
        step(1);
        chk({5'h00, pipe_state}, 8'h04);
        chk(st[0], 8'h24);
        i_cpu.wr_clear(0, 8'hff);
        // count expiry steps down; with dir high it waits for fifo empty
        expire();
        chk({5'h00, pipe_state}, 8'h02);
        chk(st[0], 8'h01);
        i_cpu.wr_clear(0, 8'hff);
        dir = 1'b1;
        expire();
        chk({5'h00, pipe_state}, 8'h02);
        fifo_empty_flag = 1'b1;
        step(3);
        chk({5'h00, pipe_state}, 8'h01);
        dir = 1'b0;
        fifo_empty_flag = 1'b0;
        i_cpu.wr_clear(0, 8'hff);
        // abort returns to idle without a flag
        i_cpu.start();
        i_cpu.wr_clear(0, 8'hff);
        i_cpu.abort();
        step(2);
        chk({5'h00, pipe_state}, 8'h01);
        chk(st[0], 8'h00);
        // parity errors flag at once and freeze the pipeline
        msk[0] = 8'h08;
        i_cpu.set_sum(4'hf, 4'h0);
        host_bus_parity_err = 1'b1;
        step(1);
        host_bus_parity_err = 1'b0;
        chk(st[0], 8'h0c);
        i_cpu.start();
        step(1);
        chk({5'h00, pipe_state}, 8'h01);
        chk(st[0], 8'h0c);
        chk({7'h00, irq_out_a}, 8'h01);
        i_cpu.wr_clear(0, 8'hff);
        buffer_bus_parity_err = 1'b1;
        step(1);
        buffer_bus_parity_err = 1'b0;
        chk(st[0], 8'h14);
        i_cpu.wr_clear(0, 8'hff);
        step(2);
        chk({7'h00, irq_out_a}, 8'h00);
        close_out();
    end
endmodule
